// [iwu_map.vh]
// register offsets, reset values and field positions of the interrupt unit
`ifndef IWU_MAP_VH
`define IWU_MAP_VH
`define IWU_A_NMI_STATUS   5'h00
`define IWU_A_PF_CTRL      5'h01
`define IWU_A_VECTOR       5'h02
`define IWU_A_MASK_ENABLE  5'h03
`define IWU_A_PENDING      5'h04
`define IWU_A_EDGE_CLEAR   5'h05
`define IWU_A_TRIG_MODE    5'h06
`define IWU_A_TRIG_POL     5'h07
`define IWU_A_WAKE_EDGE    5'h08
`define IWU_A_WAKE_PEND    5'h09
`define IWU_A_WAKE_ENABLE  5'h0a
`define IWU_A_WAKE_CLEAR   5'h0b
`define IWU_A_WAKE_STATUS  5'h0c
`define IWU_VEC_BASE       4'h2
`define IWU_VEC_RESET      8'h20
`define IWU_BIT_PF_ARM     0
`define IWU_BIT_PF_PIN     1
`define IWU_BIT_NMI_PF     0
`define IWU_NUM_INT        16
`define IWU_NUM_WAKE       24
`define IWU_INT_SERIAL     3
`define IWU_INT_KEYSCAN    7
`define IWU_WAKE_PWROFF    12
`define IWU_WAKE_HOSTACC   14
`endif

// [iwu_sync.v]
// two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module iwu_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire         nrst,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule // iwu_sync

// [iwu_wake.v]
// wake-up front end: asynchronous edge latches and output routing
`timescale 1ns/1ps
`include "iwu_map.vh"
module iwu_wake (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire [23:0] wake_input_line,
    input  wire [23:0] wake_edge_select,
    input  wire [23:0] wake_input_enable,
    input  wire [23:0] wake_clear_pulse,
    input  wire [23:0] wake_set_pulse,
    output wire [23:0] wake_pending_flags,
    output wire [23:0] wake_routed_output,
    output wire        serial_group_request,
    output wire        keyscan_group_request,
    output wire        wake_request
);
    wire [23:0] pend_raw;
    wire [23:0] line_s;

    // per-channel latch clocked by the input itself, works clock-stopped
    genvar i;
    generate
        for (i = 0; i < `IWU_NUM_WAKE; i = i + 1) begin : g_ch
            wire ev_clk;
            wire clr_n;
            reg  pend_q;
            // edge select 1 means high-to-low
            assign ev_clk = wake_input_line[i] ^ wake_edge_select[i];
            assign clr_n  = nrst & ~wake_clear_pulse[i];
            always @(posedge ev_clk or negedge clr_n) begin
                if (!clr_n) begin
                    pend_q <= 1'b0;
                end else begin
                    pend_q <= 1'b1; // [RULE15] [RULE16] [RULE18]
                end
            end
            assign pend_raw[i] = pend_q;
        end
    endgenerate

    // pending flags and raw lines cross into the system clock
    iwu_sync #(.W(24)) u_pend_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (pend_raw),
        .sync_out (wake_pending_flags)
    );
    iwu_sync #(.W(24)) u_line_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (wake_input_line),
        .sync_out (line_s)
    );

    // raw line when disabled, pending flag when enabled
    assign wake_routed_output = (wake_input_enable & wake_pending_flags) |
                                (~wake_input_enable & line_s); // [RULE20]
    assign serial_group_request  =
        |(wake_input_enable[7:0] & wake_pending_flags[7:0]);    // [RULE21]
    assign keyscan_group_request =
        |(wake_input_enable[23:16] & wake_pending_flags[23:16]); // [RULE21]
    assign wake_request =
        |(wake_input_enable & wake_pending_flags); // [RULE14] [RULE19]
    // software set path unused in this build: set pulses are ignored
    wire unused_set = |wake_set_pulse;
endmodule // iwu_wake

// [iwu_top.v]
// interrupt controller with power-fail trap and wake-up front end
`timescale 1ns/1ps
`include "iwu_map.vh"
// Contract
// (RULE1) nmi status bit0 sets on power-fail fall, cleared by any read
// (RULE2) trap fires when armed and power-fail pin falls
// (RULE3) arm bit cleared on reset and when the trap fires
// (RULE4) control bit1 reads live pin level, writes ignored
// (RULE5) vector reads 0010 plus code of best enabled pending input
// (RULE6) enable bit i gates input i, reset clears all
// (RULE7) software clears enable bits only with core interrupts off
// (RULE8) pending register read-only, shows pending regardless of enable
// (RULE9) write one to edge-clear clears pending edge input only
// (RULE10) mode bit 0 level, 1 edge
// (RULE11) polarity 0 low/falling, 1 high/rising
// (RULE12) software initialises base, modes, handlers, clears, enables
// (RULE13) software changes config only with core interrupts off
// (RULE14) wake front end watches 24 inputs, makes wake and interrupt
// (RULE15) per-input edge select picks rising or falling; inputs 16-23 take the select written for inputs 0-7
// (RULE16) wake pending holds until explicitly cleared
// (RULE17) idle refused while any wake input enabled and pending
// (RULE18) wake detection works without clock, synchronised afterwards
// (RULE19) wake request is OR of pending and enabled channels
// (RULE20) routed output is raw line if disabled, pending if enabled
// (RULE21) serial and keyscan group lines OR their eight enabled members
// (RULE22) input 3 gets serial group OR power-off wake; host access none
// (RULE23) fixed priority, higher number wins, vector 20h to 2Fh
// (RULE24) edges latch; level pending clears when source stops
// (RULE25) interrupt request high while any input pending and enabled
module iwu_top (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        power_fail_pin,
    input  wire [15:0] int_source,
    input  wire [23:0] wake_input_line,
    input  wire        idle_request,
    output wire        idle_grant,
    output wire        nmi_request,
    output wire        int_request,
    output wire [7:0]  vector_code,
    output wire        wake_request
);
    // register state
    reg  [15:0] mask_q;
    reg  [15:0] mode_q;
    reg  [15:0] pol_q;
    reg  [15:0] edge_pend_q;
    reg  [15:0] prev_q;
    reg         arm_q;
    reg         nmi_stat_q;
    reg         pf_prev_q;
    reg         nmi_q;
    reg  [23:0] wedge_q;
    reg  [23:0] wen_q;
    reg  [23:0] wclr_q;
    reg  [3:0]  vec_q;

    wire        pf_s;
    wire [15:0] ext_s;
    wire [23:0] wpend;
    wire [23:0] wko;
    wire        grp_ser;
    wire        grp_key;
    wire [15:0] src;
    wire [15:0] act;
    wire [15:0] rise;
    wire [15:0] fall;
    wire [15:0] edge_hit;
    wire [15:0] pending;
    wire [15:0] req;
    wire        pf_fall;
    reg  [3:0]  best;
    integer     k;

    iwu_sync #(.W(1)) u_pf_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (power_fail_pin),
        .sync_out (pf_s)
    );
    iwu_sync #(.W(16)) u_src_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (int_source),
        .sync_out (ext_s)
    );

    iwu_wake u_wake (
        .sys_clk               (sys_clk),
        .nrst                  (nrst),
        .wake_input_line       (wake_input_line),
        .wake_edge_select      (wedge_q),
        .wake_input_enable     (wen_q),
        .wake_clear_pulse      (wclr_q),
        .wake_set_pulse        (24'h000000),
        .wake_pending_flags    (wpend),
        .wake_routed_output    (wko),
        .serial_group_request  (grp_ser),
        .keyscan_group_request (grp_key),
        .wake_request          (wake_request)
    );

    // source map: wake outputs are ORed with the matching raw inputs; input 3 drops its raw input
    assign src = {ext_s[15] | wko[11], ext_s[14:12], ext_s[11] | wko[10],
                  ext_s[10] | wko[9], ext_s[9] | wko[13], ext_s[8] | wko[15],
                  ext_s[7] | grp_key, ext_s[6:4],
                  grp_ser | wko[`IWU_WAKE_PWROFF],           // [RULE22]
                  ext_s[2:1], ext_s[0] | wko[8]};
    // host access wake output wko[14] feeds no interrupt    [RULE22]

    // polarity-adjusted activity and edge detection
    assign act  = ~(src ^ pol_q);                             // [RULE11]
    assign rise = src & ~prev_q;
    assign fall = ~src & prev_q;
    assign edge_hit = (pol_q & rise) | (~pol_q & fall);      // [RULE11]
    assign pending = (mode_q & edge_pend_q) | (~mode_q & act); // [RULE10]
    assign req = pending & mask_q;                           // [RULE6]
    assign int_request = |req;                               // [RULE25]
    assign pf_fall = pf_prev_q & ~pf_s;

    // highest-numbered enabled pending input
    always @* begin
        best = 4'h0;
        for (k = 0; k < `IWU_NUM_INT; k = k + 1) begin
            if (req[k]) begin
                best = k[3:0];                               // [RULE23]
            end
        end
    end

    // edge latch, edge clear and input history
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            edge_pend_q <= 16'h0000;
            prev_q      <= 16'h0000;
        end else begin
            prev_q <= src;
            if (reg_wr && reg_addr == `IWU_A_EDGE_CLEAR) begin
                edge_pend_q <= ((edge_pend_q & ~(reg_wdata & mode_q))
                                | edge_hit) & mode_q;        // [RULE9]
            end else begin
                edge_pend_q <= (edge_pend_q | edge_hit) & mode_q; // [RULE24]
            end
        end
    end

    // power-fail trap, arm bit and nmi status
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arm_q      <= 1'b0;
            nmi_stat_q <= 1'b0;
            pf_prev_q  <= 1'b0;
            nmi_q      <= 1'b0;
        end else begin
            pf_prev_q <= pf_s;
            nmi_q     <= pf_fall & arm_q;                    // [RULE2]
            if (pf_fall & arm_q) begin
                arm_q <= 1'b0;                               // [RULE3]
            end else if (reg_wr && reg_addr == `IWU_A_PF_CTRL) begin
                arm_q <= reg_wdata[`IWU_BIT_PF_ARM];
            end
            if (pf_fall) begin
                nmi_stat_q <= 1'b1;                          // [RULE1]
            end else if (reg_rd && reg_addr == `IWU_A_NMI_STATUS) begin
                nmi_stat_q <= 1'b0;                          // [RULE1]
            end
        end
    end
    assign nmi_request = nmi_q;

    // software registers
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mask_q  <= 16'h0000;
            mode_q  <= 16'h0000;
            pol_q   <= 16'h0000;
            wedge_q <= 24'h000000;
            wen_q   <= 24'h000000;
            wclr_q  <= 24'h000000;
        end else begin
            wclr_q <= 24'h000000;
            if (reg_wr) begin
                if (reg_addr == `IWU_A_MASK_ENABLE) begin
                    mask_q <= reg_wdata;                     // [RULE6]
                end else if (reg_addr == `IWU_A_TRIG_MODE) begin
                    mode_q <= reg_wdata;                     // [RULE10]
                end else if (reg_addr == `IWU_A_TRIG_POL) begin
                    pol_q <= reg_wdata;                      // [RULE11]
                end else if (reg_addr == `IWU_A_WAKE_EDGE) begin
                    wedge_q <= {reg_wdata[7:0], reg_wdata[15:0]}; // [RULE15]
                end else if (reg_addr == `IWU_A_WAKE_ENABLE) begin
                    wen_q <= {reg_wdata[7:0], reg_wdata[15:0]};
                end else if (reg_addr == `IWU_A_WAKE_CLEAR) begin
                    wclr_q <= {reg_wdata[7:0], reg_wdata[15:0]}; // [RULE16]
                end
            end
        end
    end

    // vector code registered from the priority encoder
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vec_q <= 4'h0;
        end else begin
            vec_q <= best;                                   // [RULE5]
        end
    end
    assign vector_code = {`IWU_VEC_BASE, vec_q};             // [RULE5]

    // idle allowed only with no enabled pending wake input
    assign idle_grant = idle_request & ~|(wen_q & wpend);    // [RULE17]

    // read data, one cycle after the strobe
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr == `IWU_A_NMI_STATUS) begin
                    reg_rdata <= {15'h0000, nmi_stat_q};     // [RULE1]
                end else if (reg_addr == `IWU_A_PF_CTRL) begin
                    reg_rdata <= {14'h0000, pf_s, arm_q};    // [RULE4]
                end else if (reg_addr == `IWU_A_VECTOR) begin
                    reg_rdata <= {8'h00, `IWU_VEC_BASE, best}; // [RULE5]
                end else if (reg_addr == `IWU_A_MASK_ENABLE) begin
                    reg_rdata <= mask_q;
                end else if (reg_addr == `IWU_A_PENDING) begin
                    reg_rdata <= pending;                    // [RULE8]
                end else if (reg_addr == `IWU_A_TRIG_MODE) begin
                    reg_rdata <= mode_q;
                end else if (reg_addr == `IWU_A_TRIG_POL) begin
                    reg_rdata <= pol_q;
                end else if (reg_addr == `IWU_A_WAKE_EDGE) begin
                    reg_rdata <= wedge_q[15:0];
                end else if (reg_addr == `IWU_A_WAKE_PEND) begin
                    reg_rdata <= wpend[15:0];
                end else if (reg_addr == `IWU_A_WAKE_ENABLE) begin
                    reg_rdata <= wen_q[15:0];
                end else if (reg_addr == `IWU_A_WAKE_STATUS) begin
                    reg_rdata <= {wpend[23:16], wen_q[23:16]};
                end
            end
        end
    end
endmodule // iwu_top

// [iwu_top_properties.sv]
// port-level assertions for the interrupt and wake-up unit
`timescale 1ns/1ps
`include "iwu_map.vh"
module iwu_top_properties (
    input wire        sys_clk,
    input wire        nrst,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        power_fail_pin,
    input wire [15:0] int_source,
    input wire [23:0] wake_input_line,
    input wire        idle_request,
    input wire        idle_grant,
    input wire        nmi_request,
    input wire        int_request,
    input wire [7:0]  vector_code,
    input wire        wake_request
);
    reg       pin_q;
    reg [3:0] fall_age_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // cycles since the last power-fail fall, saturating at 15
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_q      <= 1'b1;
            fall_age_q <= 4'hf;
        end else begin
            pin_q <= power_fail_pin;
            if (pin_q && !power_fail_pin)
                fall_age_q <= 4'h0;
            else if (fall_age_q != 4'hf)
                fall_age_q <= fall_age_q + 4'h1;
        end
    end
    sequence s_rd_stat;
        reg_rd && reg_addr == `IWU_A_NMI_STATUS;
    endsequence
    sequence s_rd_stat_old;
        reg_rd && reg_addr == `IWU_A_NMI_STATUS && fall_age_q == 4'hf;
    endsequence
    property p_vec_upper;
        vector_code[7:4] == `IWU_VEC_BASE;
    endproperty
    property p_vec_reset;
        $rose(nrst) |-> vector_code == `IWU_VEC_RESET;
    endproperty
    property p_quiet_reset;
        $rose(nrst) |-> !int_request && !nmi_request;
    endproperty
    property p_nmi_single;
        nmi_request |=> !nmi_request;
    endproperty
    property p_nmi_cause;
        nmi_request |-> fall_age_q <= 4'h6;
    endproperty
    property p_stat_clear;
        s_rd_stat ##2 s_rd_stat_old |=> reg_rdata == 16'h0000;
    endproperty
    property p_eclr_read;
        reg_rd && reg_addr == `IWU_A_EDGE_CLEAR |=> reg_rdata == 16'h0000;
    endproperty
    property p_idle;
        idle_grant |-> idle_request && !wake_request;
    endproperty
    a_vec_upper: assert property (p_vec_upper)
        else $error("vector upper nibble wrong");
    a_vec_reset: assert property (p_vec_reset)
        else $error("vector not 20 after reset");
    a_quiet_reset: assert property (p_quiet_reset)
        else $error("request right after reset");
    a_nmi_single: assert property (p_nmi_single)
        else $error("trap fired twice");
    a_nmi_cause: assert property (p_nmi_cause)
        else $error("trap without pin fall");
    a_stat_clear: assert property (p_stat_clear)
        else $error("nmi status not cleared by read");
    a_eclr_read: assert property (p_eclr_read)
        else $error("edge clear reads nonzero");
    a_idle: assert property (p_idle)
        else $error("idle granted unasked or with wake pending");
endmodule // iwu_top_properties
bind iwu_top iwu_top_properties iwu_top_properties_i (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_fail_pin(power_fail_pin),
    .int_source(int_source), .wake_input_line(wake_input_line),
    .idle_request(idle_request), .idle_grant(idle_grant),
    .nmi_request(nmi_request), .int_request(int_request),
    .vector_code(vector_code), .wake_request(wake_request));

// [iwu_core_model.sv]
// processor core model taking vectors during acknowledge
`timescale 1ns/1ps
module iwu_core_model #(
    parameter ACK_DELAY = 2
) (
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire       core_ie,
    input  wire       int_request,
    input  wire       nmi_request,
    input  wire [7:0] vector_code,
    output reg  [7:0] ack_vector_q,
    output reg  [7:0] nmi_count_q
);
    reg [7:0] wait_q;
    // acknowledge after a delay while interrupts are on, count traps
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q       <= 8'h00;
            ack_vector_q <= 8'h00;
            nmi_count_q  <= 8'h00;
        end else begin
            if (nmi_request)
                nmi_count_q <= nmi_count_q + 8'h01;
            wait_q <= (core_ie && int_request) ? wait_q + 8'h01 : 8'h00;
            if (wait_q == ACK_DELAY)
                ack_vector_q <= vector_code;
        end
    end
endmodule // iwu_core_model

// [iwu_top_test.sv]
// self-checking bench for the interrupt and wake-up unit
`timescale 1ns/1ps
`include "iwu_map.vh"
module iwu_top_test;
    reg         sys_clk;
    reg         nrst;
    reg  [4:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [15:0] reg_rdata;
    reg         power_fail_pin;
    reg  [15:0] int_source;
    reg  [23:0] wake_input_line;
    reg         idle_request;
    wire        idle_grant;
    wire        nmi_request;
    wire        int_request;
    wire [7:0]  vector_code;
    wire        wake_request;
    reg         core_ie;
    wire [7:0]  ack_vector_q;
    wire [7:0]  nmi_count_q;
    integer     fail_count;
    integer     checks_done;
    integer     p;
    iwu_top iwu_top_i (.sys_clk(sys_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_fail_pin(power_fail_pin), .int_source(int_source),
        .wake_input_line(wake_input_line), .idle_request(idle_request),
        .idle_grant(idle_grant), .nmi_request(nmi_request),
        .int_request(int_request), .vector_code(vector_code),
        .wake_request(wake_request));
    iwu_core_model #(.ACK_DELAY(3)) iwu_core_model_i (.sys_clk(sys_clk),
        .nrst(nrst), .core_ie(core_ie), .int_request(int_request),
        .nmi_request(nmi_request), .vector_code(vector_code),
        .ack_vector_q(ack_vector_q), .nmi_count_q(nmi_count_q));
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk16(input [15:0] got, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task chk1(input got, input exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(posedge sys_clk);
            reg_wr    <= 1'b1;
            reg_addr  <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read one register and compare the answer
    task rd(input [4:0] a, input [15:0] exp);
        begin
            @(posedge sys_clk);
            reg_rd   <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1 chk16(reg_rdata, exp);
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        fail_count = fail_count + 1;
        report_and_stop;
    end
    initial begin
        fail_count = 0;
        checks_done = 0;
        nrst = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        power_fail_pin = 1'b1;
        int_source = 16'h0000;
        wake_input_line = 24'h000000;
        idle_request = 1'b0;
        core_ie = 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(`IWU_A_VECTOR, 16'h0020);
        rd(`IWU_A_MASK_ENABLE, 16'h0000);
        rd(`IWU_A_PF_CTRL, 16'h0002);
        rd(`IWU_A_NMI_STATUS, 16'h0000);
        // setup: modes, polarity, edge clear, then read back
        wr(`IWU_A_TRIG_MODE, 16'h0020);
        wr(`IWU_A_TRIG_POL, 16'hffff);
        wr(`IWU_A_EDGE_CLEAR, 16'hffff);
        rd(`IWU_A_TRIG_MODE, 16'h0020);
        rd(`IWU_A_TRIG_POL, 16'hffff);
        rd(`IWU_A_PENDING, 16'h0000);
        rd(`IWU_A_EDGE_CLEAR, 16'h0000);
        // level sources, masking and priority
        @(posedge sys_clk) int_source <= 16'h0090;
        cyc(4);
        rd(`IWU_A_PENDING, 16'h0090);
        chk1(int_request, 1'b0);
        wr(`IWU_A_MASK_ENABLE, 16'h0010);
        @(posedge sys_clk) core_ie <= 1'b1;
        cyc(8);
        chk1(int_request, 1'b1);
        chk16({8'h00, ack_vector_q}, 16'h0024);
        @(posedge sys_clk) core_ie <= 1'b0;
        wr(`IWU_A_MASK_ENABLE, 16'h0090);
        @(posedge sys_clk) core_ie <= 1'b1;
        cyc(8);
        chk16({8'h00, ack_vector_q}, 16'h0027);
        @(posedge sys_clk) core_ie <= 1'b0;
        wr(`IWU_A_TRIG_POL, 16'hfffe);
        rd(`IWU_A_PENDING, 16'h0091);
        @(posedge sys_clk) int_source <= 16'h0000;
        cyc(4);
        rd(`IWU_A_PENDING, 16'h0001);
        chk1(int_request, 1'b0);
        wr(`IWU_A_TRIG_POL, 16'hffff);
        wr(`IWU_A_MASK_ENABLE, 16'h0000);
        // edge source on input 5, falling then rising
        for (p = 0; p < 2; p = p + 1) begin
            wr(`IWU_A_TRIG_POL, {10'h3ff, p[0], 5'h1f});
            wr(`IWU_A_EDGE_CLEAR, 16'h0020);
            @(posedge sys_clk) int_source <= 16'h00a0;
            cyc(4);
            rd(`IWU_A_PENDING, {8'h00, 2'b10, p[0], 5'h00});
            @(posedge sys_clk) int_source <= 16'h0080;
            cyc(4);
            rd(`IWU_A_PENDING, 16'h00a0);
            wr(`IWU_A_EDGE_CLEAR, 16'hffdf);
            rd(`IWU_A_PENDING, 16'h00a0);
            wr(`IWU_A_EDGE_CLEAR, 16'h0020);
            rd(`IWU_A_PENDING, 16'h0080);
        end
        @(posedge sys_clk) int_source <= 16'h0000;
        // power-fail trap, armed then disarmed
        wr(`IWU_A_PF_CTRL, 16'h0001);
        rd(`IWU_A_PF_CTRL, 16'h0003);
        @(posedge sys_clk) power_fail_pin <= 1'b0;
        cyc(16);
        chk16({8'h00, nmi_count_q}, 16'h0001);
        rd(`IWU_A_PF_CTRL, 16'h0000);
        rd(`IWU_A_NMI_STATUS, 16'h0001);
        rd(`IWU_A_NMI_STATUS, 16'h0000);
        wr(`IWU_A_PF_CTRL, 16'h0002);
        rd(`IWU_A_PF_CTRL, 16'h0000);
        @(posedge sys_clk) power_fail_pin <= 1'b1;
        cyc(6);
        @(posedge sys_clk) power_fail_pin <= 1'b0;
        cyc(10);
        chk16({8'h00, nmi_count_q}, 16'h0001);
        rd(`IWU_A_NMI_STATUS, 16'h0001);
        // wake channel 12: pending, wake, idle refusal, route to input 3
        wr(`IWU_A_WAKE_EDGE, 16'h0000);
        wr(`IWU_A_WAKE_CLEAR, 16'hffff);
        wr(`IWU_A_WAKE_ENABLE, 16'h1001);
        @(posedge sys_clk) idle_request <= 1'b1;
        cyc(4);
        chk1(idle_grant, 1'b1);
        @(posedge sys_clk) wake_input_line <= 24'h001000;
        cyc(6);
        chk1(wake_request, 1'b1);
        chk1(idle_grant, 1'b0);
        rd(`IWU_A_PENDING, 16'h0008);
        @(posedge sys_clk) wake_input_line <= 24'h000000;
        cyc(6);
        rd(`IWU_A_WAKE_PEND, 16'h1000);
        wr(`IWU_A_WAKE_CLEAR, 16'h1000);
        cyc(4);
        chk1(wake_request, 1'b0);
        chk1(idle_grant, 1'b1);
        wr(`IWU_A_WAKE_EDGE, 16'h1000);
        wr(`IWU_A_WAKE_CLEAR, 16'hffff);
        @(posedge sys_clk) wake_input_line <= 24'h001000;
        cyc(6);
        rd(`IWU_A_WAKE_PEND, 16'h0000);
        @(posedge sys_clk) wake_input_line <= 24'h000000;
        cyc(6);
        rd(`IWU_A_WAKE_PEND, 16'h1000);
        wr(`IWU_A_WAKE_EDGE, 16'h0000);
        wr(`IWU_A_WAKE_CLEAR, 16'hffff);
        // grouped lines, then raw routing with enables off
        @(posedge sys_clk) wake_input_line <= 24'h010001;
        cyc(6);
        rd(`IWU_A_PENDING, 16'h0088);
        rd(`IWU_A_WAKE_STATUS, 16'h0101);
        wr(`IWU_A_WAKE_CLEAR, 16'hffff);
        wr(`IWU_A_WAKE_ENABLE, 16'h0000);
        @(posedge sys_clk) wake_input_line <= 24'h004100;
        cyc(6);
        rd(`IWU_A_PENDING, 16'h0001);
        report_and_stop;
    end
endmodule // iwu_top_test
